/* File: src/pew_irq_front.sv */
// pin edge interrupt, counter rollover, wake and context shadow logic
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pew_regs.svh"

module pew_irq_front
  import pew_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic sys_clk_i,                 // system clock, 100 MHz
  input wire logic reset_i,                   // synchronous reset, active high
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,       // byte address
  input wire logic avs_read_i,                // read request
  input wire logic avs_write_i,               // write request
  input wire logic [31:0] avs_writedata_i,    // write data
  input wire logic [3:0] avs_byteenable_i,    // byte lanes
  output logic [31:0] avs_readdata_o,         // read data
  output logic avs_waitrequest_o,             // stall the master
  // pins
  input wire logic [PORT_W-1:0] port_pins_i,  // second io port levels
  input wire logic ext_pin_i,                 // dedicated edge interrupt pin
  input wire logic counter_clk_pin_i,         // external counter clock
  // core side
  input wire logic sleep_req_i,               // core executes sleep
  input wire logic instr_retire_i,            // core finished an instruction
  input wire logic irq_return_i,              // core executes return from irq
  input wire logic [14:0] return_pc_i,        // pc to push on entry
  input wire pew_ctx_t ctx_i,                 // live context registers
  output logic core_sleep_o,                  // core held in sleep
  output logic irq_pending_o,                 // some enabled source pending
  output logic vector_o,                      // branch to interrupt vector
  output logic stack_push_o,                  // push push_pc_o
  output logic [14:0] push_pc_o,              // return pc to stack
  output logic ctx_restore_o,                 // load ctx_o into live regs
  output pew_ctx_t ctx_o                      // shadow context
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (PORT_W != PEW_PORT_W) begin : g_bad_width
    $error("pew_irq_front: PORT_W must match the state struct width");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pew_state_t s;
  pew_state_t next_s;

  logic [PORT_W-1:0] pin_edges;
  logic ext_edge;
  logic cclk_rise;
  logic cnt_async;
  logic cnt_tick;
  logic rollover;
  logic ext_req;
  logic chg_req;
  logic roll_req;
  logic irq_pending;
  logic wake_cond;
  logic bus_req;
  logic bus_wr;
  logic [2:0] shadow_idx;
  logic in_shadow;
  logic [7:0] wbyte;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  function automatic pew_shadow_t save_ctx(input pew_ctx_t c);
    pew_ctx_t m;
    m = c;
    m.status = c.status & `PEW_STATUS_SAVE_MASK;
    m.bank_select_reg = c.bank_select_reg & `PEW_BSR_MASK;
    m.pc_upper_latch = c.pc_upper_latch & `PEW_PC_UPPER_LATCH_MASK;
    save_ctx = pew_shadow_t'(m);
  endfunction

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  // second stage against a third copy; the first stage feeds only the second
  assign pin_edges = (s.pin_s2 & ~s.pin_prev & s.rise_en)
                   | (~s.pin_s2 & s.pin_prev & s.fall_en);
  assign ext_edge = s.edge_sel ? (s.ext_s2 & ~s.ext_prev)
                               : (~s.ext_s2 & s.ext_prev);
  assign cclk_rise = s.cclk_s2 & ~s.cclk_prev;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // only the external, unsynchronised mode keeps counting with the core asleep
  assign cnt_async = s.cnt_sync_dis && (s.cnt_csel == `PEW_CSEL_EXT);
  assign cnt_tick = s.cnt_run
                  && ((s.cnt_csel == `PEW_CSEL_EXT) ? cclk_rise : 1'b1)
                  && ((s.fsm != PEW_SLEEP) || cnt_async);
  assign rollover = cnt_tick && (s.cnt == `PEW_CNT_MAX);

  // ------------------------------------------------------------
  // interrupt request and wake
  // ------------------------------------------------------------
  assign ext_req = s.ext_pin_irq_flag & s.ext_pin_irq_enable;
  assign chg_req = (|s.chg_flag) & s.change_irq_master_enable;
  assign roll_req = s.roll_flag & s.roll_ie & s.peripheral_irq_enable & s.cnt_run;
  assign irq_pending = ext_req | chg_req | roll_req;
  // enables were frozen at sleep entry
  assign wake_cond = (s.ext_pin_irq_flag & s.wake_en[2])
                   | ((|s.chg_flag) & s.wake_en[1])
                   | (s.roll_flag & s.wake_en[0] & cnt_async);

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_wr = avs_write_i & s.bus_ack;
  assign in_shadow = (avs_address_i >= `PEW_OFF_SHADOW_BASE)
                  && (avs_address_i <= `PEW_OFF_SHADOW_LAST)
                  && (avs_address_i[1:0] == 2'h0);
  assign shadow_idx = 3'((avs_address_i - `PEW_OFF_SHADOW_BASE) >> 2);
  assign wbyte = avs_writedata_i[7:0];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.vector = 1'b0;
    next_s.push = 1'b0;
    next_s.restore = 1'b0;

    // synchronisers
    next_s.pin_s1 = port_pins_i;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_prev = s.pin_s2;
    next_s.ext_s1 = ext_pin_i;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_prev = s.ext_s2;
    next_s.cclk_s1 = counter_clk_pin_i;
    next_s.cclk_s2 = s.cclk_s1;
    next_s.cclk_prev = s.cclk_s2;

    // one wait cycle per access, data latched in the first
    next_s.bus_ack = bus_req & ~s.bus_ack;
    if (avs_read_i && !s.bus_ack) begin
      next_s.rdata = 32'h0000_0000;
      if (hit(avs_address_i, `PEW_OFF_IRQ_CTRL)) begin
        next_s.rdata[`PEW_IC_GIE] = s.global_irq_enable;
        next_s.rdata[`PEW_IC_PERIPHERAL_IRQ_ENABLE] = s.peripheral_irq_enable;
        next_s.rdata[`PEW_IC_EXT_PIN_IRQ_ENABLE] = s.ext_pin_irq_enable;
        next_s.rdata[`PEW_IC_CHANGE_IRQ_MASTER_ENABLE] = s.change_irq_master_enable;
        next_s.rdata[`PEW_IC_EXT_PIN_IRQ_FLAG] = s.ext_pin_irq_flag;
        next_s.rdata[`PEW_IC_SUMMARY] = |s.chg_flag;
        next_s.rdata[`PEW_IC_EDGE_SEL] = s.edge_sel;
      end else if (hit(avs_address_i, `PEW_OFF_RISE_EN)) begin
        next_s.rdata[PORT_W-1:0] = s.rise_en;
      end else if (hit(avs_address_i, `PEW_OFF_FALL_EN)) begin
        next_s.rdata[PORT_W-1:0] = s.fall_en;
      end else if (hit(avs_address_i, `PEW_OFF_CHG_FLAG)) begin
        next_s.rdata[PORT_W-1:0] = s.chg_flag;
      end else if (hit(avs_address_i, `PEW_OFF_CNT_CTRL)) begin
        next_s.rdata[`PEW_CC_RUN] = s.cnt_run;
        next_s.rdata[`PEW_CC_SYNC_DIS] = s.cnt_sync_dis;
        next_s.rdata[`PEW_CC_OSC_EN] = s.cnt_osc_en;
        next_s.rdata[`PEW_CC_CSEL_HI:`PEW_CC_CSEL_LO] = s.cnt_csel;
      end else if (hit(avs_address_i, `PEW_OFF_PERIPH_EN)) begin
        next_s.rdata[`PEW_PE_ROLL] = s.roll_ie;
      end else if (hit(avs_address_i, `PEW_OFF_PERIPH_FLAG)) begin
        next_s.rdata[`PEW_PF_ROLL] = s.roll_flag;
      end else if (hit(avs_address_i, `PEW_OFF_CNT_VALUE)) begin
        next_s.rdata[15:0] = s.cnt;
      end else if (hit(avs_address_i, `PEW_OFF_CORE_STAT)) begin
        next_s.rdata[`PEW_CS_FSM_HI:`PEW_CS_FSM_LO] = s.fsm;
        next_s.rdata[`PEW_CS_WAKE_HI:`PEW_CS_WAKE_LO] = s.wake_en;
        next_s.rdata[`PEW_CS_PEND] = irq_pending;
      end else if (in_shadow) begin
        next_s.rdata[7:0] = s.shadow[shadow_idx];
      end
    end

    // register writes
    if (bus_wr && avs_byteenable_i[0]) begin
      if (hit(avs_address_i, `PEW_OFF_IRQ_CTRL)) begin
        next_s.global_irq_enable = wbyte[`PEW_IC_GIE];
        next_s.peripheral_irq_enable = wbyte[`PEW_IC_PERIPHERAL_IRQ_ENABLE];
        next_s.ext_pin_irq_enable = wbyte[`PEW_IC_EXT_PIN_IRQ_ENABLE];
        next_s.change_irq_master_enable = wbyte[`PEW_IC_CHANGE_IRQ_MASTER_ENABLE];
        next_s.ext_pin_irq_flag = wbyte[`PEW_IC_EXT_PIN_IRQ_FLAG];
      end
      if (hit(avs_address_i, `PEW_OFF_RISE_EN)) begin
        next_s.rise_en = wbyte[PORT_W-1:0];
      end
      if (hit(avs_address_i, `PEW_OFF_FALL_EN)) begin
        next_s.fall_en = wbyte[PORT_W-1:0];
      end
      if (hit(avs_address_i, `PEW_OFF_CHG_FLAG)) begin
        next_s.chg_flag = wbyte[PORT_W-1:0];
      end
      if (hit(avs_address_i, `PEW_OFF_CNT_CTRL)) begin
        next_s.cnt_run = wbyte[`PEW_CC_RUN];
        next_s.cnt_sync_dis = wbyte[`PEW_CC_SYNC_DIS];
        next_s.cnt_osc_en = wbyte[`PEW_CC_OSC_EN];
        next_s.cnt_csel = wbyte[`PEW_CC_CSEL_HI:`PEW_CC_CSEL_LO];
      end
      if (hit(avs_address_i, `PEW_OFF_PERIPH_EN)) begin
        next_s.roll_ie = wbyte[`PEW_PE_ROLL];
      end
      if (hit(avs_address_i, `PEW_OFF_PERIPH_FLAG)) begin
        next_s.roll_flag = wbyte[`PEW_PF_ROLL];
      end
      if (in_shadow) begin
        next_s.shadow[shadow_idx] = wbyte;
      end
    end
    if (bus_wr && avs_byteenable_i[1] && hit(avs_address_i, `PEW_OFF_IRQ_CTRL)) begin
      next_s.edge_sel = avs_writedata_i[`PEW_IC_EDGE_SEL];
    end

    // counter: a software write beats the increment of the same cycle
    if (cnt_tick) begin
      next_s.cnt = 16'(s.cnt + 16'h0001);
    end
    if (bus_wr && hit(avs_address_i, `PEW_OFF_CNT_VALUE)) begin
      if (avs_byteenable_i[0]) begin
        next_s.cnt[7:0] = wbyte;
      end
      if (avs_byteenable_i[1]) begin
        next_s.cnt[15:8] = avs_writedata_i[15:8];
      end
    end

    // hardware sets beat software clears of the same cycle
    next_s.chg_flag = next_s.chg_flag | pin_edges;
    if (ext_edge) begin
      next_s.ext_pin_irq_flag = 1'b1;
    end
    if (rollover) begin
      next_s.roll_flag = 1'b1;
    end

    // sequencing against the core
    unique case (s.fsm)
      PEW_RUN: begin
        if (irq_return_i) begin
          next_s.restore = 1'b1;
          next_s.global_irq_enable = 1'b1;
        end else if (instr_retire_i && s.global_irq_enable && irq_pending) begin
          next_s.vector = 1'b1;
          next_s.push = 1'b1;
          next_s.ret_pc = return_pc_i;
          next_s.shadow = save_ctx(ctx_i);
          next_s.global_irq_enable = 1'b0;
        end else if (sleep_req_i) begin
          next_s.fsm = PEW_SLEEP;
          next_s.wake_en = {s.ext_pin_irq_enable, s.change_irq_master_enable, s.roll_ie & s.peripheral_irq_enable & s.cnt_run};
        end
      end
      PEW_SLEEP: begin
        if (wake_cond) begin
          next_s.fsm = PEW_WAKE_ONE;
        end
      end
      PEW_WAKE_ONE: begin
        // the instruction after sleep retires first
        if (instr_retire_i) begin
          next_s.fsm = PEW_RUN;
          if (s.global_irq_enable && irq_pending) begin
            next_s.vector = 1'b1;
            next_s.push = 1'b1;
            next_s.ret_pc = return_pc_i;
            next_s.shadow = save_ctx(ctx_i);
            next_s.global_irq_enable = 1'b0;
          end
        end
      end
      default: begin
        next_s.fsm = PEW_RUN;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s <= '0;
      s.fsm <= PEW_RUN;
      s.cnt <= `PEW_CNT_RST;
      s.rise_en <= `PEW_BYTE_RST;
      s.fall_en <= `PEW_BYTE_RST;
      s.chg_flag <= `PEW_BYTE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = bus_req & ~s.bus_ack;
  assign core_sleep_o = (s.fsm == PEW_SLEEP);
  assign irq_pending_o = irq_pending;
  assign vector_o = s.vector;
  assign stack_push_o = s.push;
  assign push_pc_o = s.ret_pc;
  assign ctx_restore_o = s.restore;
  assign ctx_o = pew_ctx_t'(s.shadow);

endmodule

/* File: src/pew_regs.svh */
// register map, field positions, reset values and masks of the pin edge interrupt block
`ifndef PEW_REGS_SVH
`define PEW_REGS_SVH

// ------------------------------------------------------------
// byte offsets
// ------------------------------------------------------------
`define PEW_OFF_IRQ_CTRL 8'h00
`define PEW_OFF_RISE_EN 8'h04
`define PEW_OFF_FALL_EN 8'h08
`define PEW_OFF_CHG_FLAG 8'h0C
`define PEW_OFF_CNT_CTRL 8'h10
`define PEW_OFF_PERIPH_EN 8'h14
`define PEW_OFF_PERIPH_FLAG 8'h18
`define PEW_OFF_CNT_VALUE 8'h1C
`define PEW_OFF_CORE_STAT 8'h20
`define PEW_OFF_SHADOW_BASE 8'h40
`define PEW_OFF_SHADOW_LAST 8'h5C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PEW_IC_GIE 7
`define PEW_IC_PERIPHERAL_IRQ_ENABLE 6
`define PEW_IC_EXT_PIN_IRQ_ENABLE 4
`define PEW_IC_CHANGE_IRQ_MASTER_ENABLE 3
`define PEW_IC_EXT_PIN_IRQ_FLAG 1
`define PEW_IC_SUMMARY 0
`define PEW_IC_EDGE_SEL 8
`define PEW_CC_RUN 0
`define PEW_CC_SYNC_DIS 2
`define PEW_CC_OSC_EN 3
`define PEW_CC_CSEL_HI 7
`define PEW_CC_CSEL_LO 6
`define PEW_PE_ROLL 0
`define PEW_PF_ROLL 0
`define PEW_CS_FSM_HI 2
`define PEW_CS_FSM_LO 0
`define PEW_CS_WAKE_HI 6
`define PEW_CS_WAKE_LO 4
`define PEW_CS_PEND 7

// ------------------------------------------------------------
// values and masks
// ------------------------------------------------------------
`define PEW_CSEL_EXT 2'h2
`define PEW_STATUS_SAVE_MASK 8'hE7
`define PEW_BSR_MASK 8'h1F
`define PEW_PC_UPPER_LATCH_MASK 8'h7F
`define PEW_CNT_MAX 16'hFFFF
`define PEW_CNT_RST 16'h0000
`define PEW_BYTE_RST 8'h00

`endif

/* File: src/pew_pkg.sv */
// types shared by the pin edge interrupt block
package pew_pkg;

  localparam int PEW_PORT_W = 8;
  localparam int PEW_SHADOW_N = 8;

  typedef enum logic [2:0] {
    PEW_RUN      = 3'h1,
    PEW_SLEEP    = 3'h2,
    PEW_WAKE_ONE = 3'h4
  } pew_fsm_t;

  // byte 0 is the lowest field so the struct casts to a byte array by index
  typedef struct packed {
    logic [7:0] fsr1h;
    logic [7:0] fsr1l;
    logic [7:0] fsr0h;
    logic [7:0] fsr0l;
    logic [7:0] pc_upper_latch;
    logic [7:0] bank_select_reg;
    logic [7:0] status;
    logic [7:0] w;
  } pew_ctx_t;

  typedef logic [PEW_SHADOW_N-1:0][7:0] pew_shadow_t;

  typedef struct packed {
    pew_fsm_t fsm;
    logic [PEW_PORT_W-1:0] pin_s1;
    logic [PEW_PORT_W-1:0] pin_s2;
    logic [PEW_PORT_W-1:0] pin_prev;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic cclk_s1;
    logic cclk_s2;
    logic cclk_prev;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic ext_pin_irq_enable;
    logic change_irq_master_enable;
    logic ext_pin_irq_flag;
    logic edge_sel;
    logic [PEW_PORT_W-1:0] rise_en;
    logic [PEW_PORT_W-1:0] fall_en;
    logic [PEW_PORT_W-1:0] chg_flag;
    logic cnt_run;
    logic cnt_sync_dis;
    logic cnt_osc_en;
    logic [1:0] cnt_csel;
    logic roll_ie;
    logic roll_flag;
    logic [15:0] cnt;
    logic [2:0] wake_en;
    pew_shadow_t shadow;
    logic [14:0] ret_pc;
    logic vector;
    logic push;
    logic restore;
    logic bus_ack;
    logic [31:0] rdata;
  } pew_state_t;

endpackage

/* File: test/pew_irq_front_assertions.sv */
// concurrent checks on the ports of the pin edge interrupt block
`timescale 1ns/1ps
`include "pew_regs.svh"

module pew_irq_front_assertions
  import pew_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic sys_clk_i,                // clock
  input wire logic reset_i,                  // reset
  input wire logic [7:0] avs_address_i,      // address
  input wire logic avs_read_i,               // read
  input wire logic avs_write_i,              // write
  input wire logic [31:0] avs_writedata_i,   // write data
  input wire logic [3:0] avs_byteenable_i,   // lanes
  input wire logic [31:0] avs_readdata_o,    // read data
  input wire logic avs_waitrequest_o,        // stall
  input wire logic [PORT_W-1:0] port_pins_i, // port pins
  input wire logic ext_pin_i,                // edge pin
  input wire logic counter_clk_pin_i,        // counter clock
  input wire logic sleep_req_i,              // sleep
  input wire logic instr_retire_i,           // retire
  input wire logic irq_return_i,             // return
  input wire logic [14:0] return_pc_i,       // pc
  input wire pew_ctx_t ctx_i,                // live context
  input wire logic core_sleep_o,             // asleep
  input wire logic irq_pending_o,            // pending
  input wire logic vector_o,                 // vector
  input wire logic stack_push_o,             // push
  input wire logic [14:0] push_pc_o,         // pushed pc
  input wire logic ctx_restore_o,            // restore
  input wire pew_ctx_t ctx_o                 // shadows
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  AST_PUSH_PC: assert property (vector_o |-> push_pc_o == $past(return_pc_i))
    else $error("pushed pc differs from pc at entry");
  AST_SAVE_CTX: assert property (vector_o |-> ctx_o.w == $past(ctx_i.w)
      && ctx_o.status == ($past(ctx_i.status) & `PEW_STATUS_SAVE_MASK)
      && ctx_o.bank_select_reg == ($past(ctx_i.bank_select_reg) & `PEW_BSR_MASK))
    else $error("context not copied into shadows at entry");
  AST_VEC_PULSE: assert property (vector_o |-> stack_push_o ##1 !vector_o && !stack_push_o)
    else $error("vector and push not a single joint pulse");
  AST_VEC_CAUSE: assert property (vector_o |-> $past(instr_retire_i) && $past(irq_pending_o))
    else $error("vector without retire and pending source");
  AST_NO_VEC_ASLEEP: assert property (core_sleep_o |-> !vector_o)
    else $error("vector while core asleep");
  AST_RESTORE: assert property (irq_return_i && !core_sleep_o |=> ctx_restore_o && !vector_o)
    else $error("return did not restore context");
  AST_RESTORE_CAUSE: assert property (ctx_restore_o |-> $past(irq_return_i))
    else $error("restore without return");
  AST_SLEEP_ENTRY: assert property (sleep_req_i && !core_sleep_o && !instr_retire_i
      && !irq_return_i |=> core_sleep_o)
    else $error("sleep request ignored");
  AST_FIRST_WAIT: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("request accepted without its wait cycle");
  AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
endmodule

bind pew_irq_front pew_irq_front_assertions #(.PORT_W(PORT_W)) i_chk (.*);

/* File: test/pew_pin_model.sv */
// model of the pins around the block: port levels, edge pin, gated counter clock
`timescale 1ns/1ps

module pew_pin_model
  import pew_pkg::*;
(
  input wire logic sys_clk_i,                  // reference clock
  input wire logic [PEW_PORT_W-1:0] pin_cmd_i, // wanted port levels
  input wire logic ext_cmd_i,                  // wanted edge pin level
  input wire logic cclk_run_i,                 // let counter clock run
  output logic [PEW_PORT_W-1:0] port_pins_o,   // port pins
  output logic ext_pin_o,                      // edge pin
  output logic counter_clk_o                   // counter clock pin
);
  logic [2:0] div = 3'h0;
  logic cclk = 1'b0;

  // pins follow at once so an edge lands on a chosen cycle
  assign port_pins_o = pin_cmd_i;
  assign ext_pin_o = ext_cmd_i;
  assign counter_clk_o = cclk;

  // ------------------------------------------------------------
  // counter clock
  // ------------------------------------------------------------
  // runs apart from the core so it counts in sleep; parked low when off
  always @(posedge sys_clk_i) begin
    div <= div + 3'h1;
    if (!cclk_run_i) begin
      cclk <= 1'b0;
    end else if (div == 3'h7) begin
      cclk <= !cclk;
    end
  end
endmodule

/* File: test/tb_pin_edge_interrupt_and_wake_logic.sv */
// self-checking bench for the pin edge interrupt block
`timescale 1ns/1ps
`include "pew_regs.svh"

module tb_pin_edge_interrupt_and_wake_logic
  import pew_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] pin_cmd = 8'h00;
  logic ext_cmd = 1'b0;
  logic cclk_run = 1'b0;
  logic [7:0] port_pins_i;
  logic ext_pin_i;
  logic counter_clk_pin_i;
  logic sleep_req_i = 1'b0;
  logic instr_retire_i = 1'b0;
  logic irq_return_i = 1'b0;
  logic [14:0] return_pc_i = 15'h1234;
  pew_ctx_t ctx_i = 64'hF1E2D3C4B5A6FF5A;
  logic core_sleep_o;
  logic irq_pending_o;
  logic vector_o;
  logic stack_push_o;
  logic [14:0] push_pc_o;
  logic ctx_restore_o;
  pew_ctx_t ctx_o;
  logic [63:0] sh;
  int num_errors = 0;
  int check_count = 0;
  int vec_n = 0;
  int n;

  pew_irq_front i_dut (.*);
  pew_pin_model i_pins (.sys_clk_i(sys_clk_i), .pin_cmd_i(pin_cmd), .ext_cmd_i(ext_cmd),
    .cclk_run_i(cclk_run), .port_pins_o(port_pins_i), .ext_pin_o(ext_pin_i),
    .counter_clk_o(counter_clk_pin_i));

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (vector_o === 1'b1) vec_n <= vec_n + 1;
  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic drv(input logic [7:0] p, input logic e);
    @(posedge sys_clk_i);
    pin_cmd <= p;
    ext_cmd <= e;
  endtask
  // one-cycle pulse of {sleep, retire, return}; ends where the answer shows
  task automatic core(input logic [2:0] p);
    @(posedge sys_clk_i);
    {sleep_req_i, instr_retire_i, irq_return_i} <= p;
    @(posedge sys_clk_i);
    {sleep_req_i, instr_retire_i, irq_return_i} <= 3'h0;
    @(negedge sys_clk_i);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask
  task automatic wake;
    int i;
    i = 0;
    while (core_sleep_o !== 1'b0 && i < 500) begin
      @(negedge sys_clk_i);
      i++;
    end
    chk(core_sleep_o, 1'b0);
  endtask

  initial begin
    #200us;
    num_errors++;
    summarize;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    wt(18);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    rd(8'h20, 32'h1);
    wr(8'h30, 32'hFF);
    rd(8'h30, 32'h0);
    wr(8'h04, 32'h05);
    wr(8'h08, 32'h06);
    drv(8'h07, 1'b0);
    wt(8);
    drv(8'h05, 1'b0);
    wt(8);
    rd(8'h0C, 32'h07);
    rd(8'h00, 32'h01);
    chk(irq_pending_o, 1'b0);
    wr(8'h00, 32'h08);
    chk(irq_pending_o, 1'b1);
    // falling edge on pin 2 lands during the clearing write
    drv(8'h01, 1'b0);
    wr(8'h0C, 32'h07 & ~32'h07);
    wt(8);
    rd(8'h0C, 32'h04);
    wr(8'h0C, 32'h00);
    rd(8'h00, 32'h08);
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, 32'h10 | (s << 8));
      drv(8'h01, s[0]);
      wt(8);
      wr(8'h00, 32'h10 | (s << 8));
      drv(8'h01, !s[0]);
      wt(8);
      rd(8'h00, 32'h10 | (s << 8));
      drv(8'h01, s[0]);
      wt(8);
      rd(8'h00, 32'h12 | (s << 8));
    end
    wr(8'h00, 32'h192);
    chk(irq_pending_o, 1'b1);
    sh = ctx_i & {32'hFFFFFFFF, `PEW_PC_UPPER_LATCH_MASK, `PEW_BSR_MASK, `PEW_STATUS_SAVE_MASK, 8'hFF};
    core(3'h2);
    chk(vector_o, 1'b1);
    chk(push_pc_o, 15'h1234);
    rd(8'h00, 32'h112);
    for (int i = 0; i < 8; i++) rd(8'h40 + 8'(i * 4), 32'(sh[i*8 +: 8]));
    wr(8'h40, 32'hA5);
    wr(8'h00, 32'h110);
    @(posedge sys_clk_i);
    ctx_i <= 64'h0;
    core(3'h1);
    chk(ctx_restore_o, 1'b1);
    chk(ctx_o.w, 8'hA5);
    chk(ctx_o.status, sh[15:8]);
    rd(8'h00, 32'h190);
    // counter primed two steps below rollover, flag cleared before enabling
    wr(8'h1C, 32'hFFFE);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h85);
    wr(8'h00, 32'hC0);
    core(3'h4);
    chk(core_sleep_o, 1'b1);
    @(posedge sys_clk_i);
    cclk_run <= 1'b1;
    wake;
    @(posedge sys_clk_i);
    cclk_run <= 1'b0;
    chk(vector_o, 1'b0);
    core(3'h2);
    chk(vector_o, 1'b1);
    rd(8'h18, 32'h1);
    wr(8'h18, 32'h0);
    core(3'h1);
    wr(8'h04, 32'h08);
    wr(8'h0C, 32'h00);
    wr(8'h00, 32'h08);
    core(3'h4);
    chk(core_sleep_o, 1'b1);
    drv(8'h09, 1'b1);
    wake;
    rd(8'h0C, 32'h08);
    n = vec_n;
    core(3'h2);
    wt(4);
    chk(vec_n, n);
    summarize;
  end
endmodule
